// ==== common/hce_cfg.svh ====
// offsets, field positions, reset values and timing counts of the encoder
`ifndef HCE_CFG_SVH
`define HCE_CFG_SVH

// ****************************************
// clock and times
// ****************************************
`define HCE_CLK_MHZ 250
`define HCE_TE100_US 100
`define HCE_LED_HALF_MS 100
`define HCE_SHUTOFF_S 25
`define HCE_PSETUP_MIN_US 3500
`define HCE_PSETUP_MAX_US 4500
`define HCE_ERASE_MAX_US 2200
`define HCE_WRITE_MAX_US 36000

// ****************************************
// word format and memory layout
// ****************************************
`define HCE_WORD_BITS 66
`define HCE_GUARD_ELEM 15
`define HCE_NV_WORDS 12
`define HCE_NV_BITS 192
`define HCE_NV_SER_LO 6
`define HCE_NV_SER_HI 7
`define HCE_NV_SEED_LO 8
`define HCE_NV_SEED_HI 9
`define HCE_NV_CFG 11

// ****************************************
// configuration word fields
// ****************************************
`define HCE_CFG_VTRIP 12
`define HCE_CFG_RATE_LO 13
`define HCE_CFG_RATE_HI 14
`define HCE_CFG_ENV 15

// ****************************************
// register offsets and reset values
// ****************************************
`define HCE_OFF_CTRL 8'h00
`define HCE_OFF_HOP 8'h04
`define HCE_OFF_ENVSN 8'h08
`define HCE_OFF_STATUS 8'h0C
`define HCE_OFF_CONFIG 8'h10
`define HCE_RST_CTRL 1'h0
`define HCE_RST_HOP 32'h0000_0000
`define HCE_RST_ENVSN 28'h000_0000

`endif

// ==== common/hce_pkg.sv ====
// types shared by the encoder control logic
package hce_pkg;

  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_SEND,
    ST_GUARD,
    ST_SHUT,
    ST_PLOAD,
    ST_PVERIFY
  } hce_state_t;

  // transmitted code word, sent from bit 0 upward
  typedef struct packed {
    logic repeat_flag;
    logic low_battery_flag;
    logic [3:0] btn;
    logic [27:0] serial;
    logic [31:0] enc;
  } hce_word_t;

  // complete state of the encoder
  typedef struct packed {
    hce_state_t st;
    logic auto_off;
    logic [31:0] hop;
    logic [27:0] env_sn;
    hce_word_t word;
    logic [6:0] bit_idx;
    logic [1:0] phase;
    logic [19:0] elem_cnt;
    logic [1:0] slot;
    logic blank;
    logic [34:0] hold_cnt;
    logic [20:0] setup_cnt;
    logic b3_prev;
    logic din_prev;
    logic [11:0][15:0] mem;
    logic [15:0] shreg;
    logic [3:0] bitcnt;
    logic [3:0] widx;
    logic [7:0] vbit;
    logic prog_done;
    logic [24:0] led_cnt;
    logic led_tog;
    logic pin_out;
    logic [31:0] prdata;
  } hce_regs_t;

endpackage

// ==== rtl/hce_encoder.sv ====
// code-hopping encoder transmit and programming control with apb access
`timescale 1ns/1ps
`include "hce_cfg.svh"

module hce_encoder #(
  parameter logic [19:0] TE100_CYC = 20'(`HCE_TE100_US * `HCE_CLK_MHZ),
  parameter logic [24:0] LED_HALF_CYC =
    25'(`HCE_LED_HALF_MS * 1000 * `HCE_CLK_MHZ),
  parameter logic [34:0] SHUTOFF_CYC =
    35'(64'(`HCE_SHUTOFF_S) * 64'd1000000 * 64'(`HCE_CLK_MHZ)),
  parameter logic [20:0] PSETUP_MIN_CYC =
    21'(`HCE_PSETUP_MIN_US * `HCE_CLK_MHZ),
  parameter logic [20:0] PSETUP_MAX_CYC =
    21'(`HCE_PSETUP_MAX_US * `HCE_CLK_MHZ)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // buttons, button 3 doubles as programming clock
  input wire logic button_input_0,
  input wire logic button_input_1,
  input wire logic button_input_2,
  input wire logic button_input_3_prog_clock,
  // serial data pin, two-way
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe,
  // supply comparator
  input wire logic supply_low,
  output logic vtrip_high_sel,
  // led drive, low means lit
  output logic led
);

  hce_pkg::hce_regs_t r;
  hce_pkg::hce_regs_t n;
  hce_pkg::hce_word_t fresh;
  logic [3:0] buttons;
  logic [15:0] cfg;
  logic [1:0] rate;
  logic [19:0] te_cyc;
  logic b3_rise;
  logic prog_entry;
  logic shut_now;
  logic abort;
  logic elem_end;
  logic acc;
  logic mapped;
  logic blank_next;

  // ****************************************
  // decoded inputs and configuration
  // ****************************************
  assign buttons = {button_input_3_prog_clock, button_input_2,
                    button_input_1, button_input_0};
  assign cfg = r.mem[`HCE_NV_CFG];
  assign rate = {cfg[`HCE_CFG_RATE_HI], cfg[`HCE_CFG_RATE_LO]};
  assign b3_rise = buttons[3] & ~r.b3_prev;
  assign elem_end = (r.elem_cnt == te_cyc - 20'h1);
  assign acc = psel & penable;
  assign mapped = (paddr == `HCE_OFF_CTRL) || (paddr == `HCE_OFF_HOP) ||
                  (paddr == `HCE_OFF_ENVSN) || (paddr == `HCE_OFF_STATUS) ||
                  (paddr == `HCE_OFF_CONFIG);

  // element length per rate selection
  always_comb begin
    unique case (rate)
      2'b00: te_cyc = 20'(TE100_CYC * 4);
      2'b01: te_cyc = 20'(TE100_CYC * 2);
      default: te_cyc = TE100_CYC;
    endcase
  end

  // silence is decided for the slot about to start, r.slot + 1
  always_comb begin
    unique case (rate)
      2'b01, 2'b10: blank_next = ~r.slot[0];
      2'b11: blank_next = (r.slot != 2'h3);
      default: blank_next = 1'b0;
    endcase
  end

  // word built from the button state at this moment
  always_comb begin
    fresh.repeat_flag = 1'b0;
    fresh.low_battery_flag = supply_low;
    fresh.btn = buttons;
    fresh.serial = {r.mem[`HCE_NV_SER_HI][11:0], r.mem[`HCE_NV_SER_LO]};
    if (cfg[`HCE_CFG_ENV]) begin
      fresh.serial = r.env_sn;
    end
    fresh.enc = r.hop;
    if (buttons == 4'hF) begin
      fresh.enc = {r.mem[`HCE_NV_SEED_HI], r.mem[`HCE_NV_SEED_LO]};
    end
  end

  // program entry only while the pin is released by us
  assign prog_entry = (r.st == hce_pkg::ST_SLEEP ||
                       r.st == hce_pkg::ST_GUARD ||
                       r.st == hce_pkg::ST_SHUT) &&
                      r.setup_cnt >= PSETUP_MIN_CYC &&
                      r.setup_cnt <= PSETUP_MAX_CYC &&
                      sdata_in && !r.din_prev && buttons == 4'b1000;
  assign shut_now = r.auto_off && r.hold_cnt >= SHUTOFF_CYC;
  // release of a button is not a new press, so it never aborts
  assign abort = |(buttons & ~r.word.btn);

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    n = r;
    n.b3_prev = buttons[3];
    n.din_prev = sdata_in;

    // setup timer for program entry, saturating past the window
    if (buttons == 4'b1000) begin
      if (r.setup_cnt <= PSETUP_MAX_CYC) begin
        n.setup_cnt = r.setup_cnt + 21'h1;
      end
    end else begin
      n.setup_cnt = 21'h0;
    end

    // hold timer for auto-shutoff
    if (buttons == 4'h0) begin
      n.hold_cnt = 35'h0;
    end else if (r.hold_cnt < SHUTOFF_CYC) begin
      n.hold_cnt = r.hold_cnt + 35'h1;
    end

    // element timing runs in every state but sleep, which holds it at zero, restarted where needed
    n.elem_cnt = elem_end ? 20'h0 : r.elem_cnt + 20'h1;

    unique case (r.st)
      hce_pkg::ST_SLEEP: begin
        n.elem_cnt = 20'h0;
        if (prog_entry) begin
          n.st = hce_pkg::ST_PLOAD;
        // button 3 alone waits out the program entry window first,
        // otherwise our own drive would hide the host's entry edge
        end else if (buttons != 4'h0 && !(buttons == 4'b1000 &&
                     r.setup_cnt <= PSETUP_MAX_CYC)) begin
          n.st = hce_pkg::ST_SEND;
        end
      end
      hce_pkg::ST_SEND: begin
        if (shut_now) begin
          n.st = hce_pkg::ST_SHUT;
        end else if (abort) begin
          n.st = hce_pkg::ST_SEND;
        end else if (elem_end) begin
          // finish the word even if the buttons are released; a new press aborts above
          n.phase = r.phase + 2'h1;
          if (r.phase == 2'h2) begin
            n.phase = 2'h0;
            n.bit_idx = r.bit_idx + 7'h1;
            if (r.bit_idx == 7'(`HCE_WORD_BITS - 1)) begin
              n.bit_idx = 7'h0;
              n.st = hce_pkg::ST_GUARD;
            end
          end
        end
      end
      hce_pkg::ST_GUARD: begin
        if (prog_entry) begin
          n.st = hce_pkg::ST_PLOAD;
        end else if (shut_now) begin
          n.st = hce_pkg::ST_SHUT;
        end else if (abort) begin
          n.st = hce_pkg::ST_SEND;
        end else if (elem_end) begin
          n.bit_idx = r.bit_idx + 7'h1;
          if (r.bit_idx == 7'(`HCE_GUARD_ELEM - 1)) begin
            n.bit_idx = 7'h0;
            n.st = (buttons != 4'h0) ? hce_pkg::ST_SEND
                                     : hce_pkg::ST_SLEEP;
          end
        end
      end
      hce_pkg::ST_SHUT: begin
        if (prog_entry) begin
          n.st = hce_pkg::ST_PLOAD;
        end else if (buttons == 4'h0) begin
          n.st = hce_pkg::ST_SLEEP;
        end
      end
      hce_pkg::ST_PLOAD: begin
        // data sampled on the rising clock edge, low bit first
        if (b3_rise) begin
          n.shreg = {sdata_in, r.shreg[15:1]};
          n.bitcnt = r.bitcnt + 4'h1;
          if (r.bitcnt == 4'hF) begin
            n.mem[r.widx] = {sdata_in, r.shreg[15:1]};
            n.widx = r.widx + 4'h1;
            if (r.widx == 4'(`HCE_NV_WORDS - 1)) begin
              n.prog_done = 1'b1;
              n.st = hce_pkg::ST_PVERIFY;
            end
          end
        end
      end
      hce_pkg::ST_PVERIFY: begin
        // one pass only, then the read-back path is closed
        if (b3_rise) begin
          n.vbit = r.vbit + 8'h1;
          if (r.vbit == 8'(`HCE_NV_BITS - 1)) begin
            n.vbit = 8'h0;
            n.prog_done = 1'b0;
            n.st = hce_pkg::ST_SLEEP;
          end
        end
      end
      default: n.st = hce_pkg::ST_SLEEP;
    endcase

    // start of a word: first press, repeat, or abort
    if (n.st == hce_pkg::ST_SEND && r.st != hce_pkg::ST_SEND) begin
      n.word = fresh;
      n.word.repeat_flag = (r.st == hce_pkg::ST_GUARD) && !abort;
      n.slot = n.word.repeat_flag ? r.slot + 2'h1 : 2'h0;
      n.blank = n.word.repeat_flag ? blank_next : 1'b0;
      n.bit_idx = 7'h0;
      n.phase = 2'h0;
      n.elem_cnt = 20'h0;
    end else if (r.st == hce_pkg::ST_SEND && abort && !shut_now) begin
      n.word = fresh;
      n.slot = 2'h0;
      n.blank = 1'b0;
      n.bit_idx = 7'h0;
      n.phase = 2'h0;
      n.elem_cnt = 20'h0;
    end else if (n.st == hce_pkg::ST_GUARD && r.st != hce_pkg::ST_GUARD) begin
      n.elem_cnt = 20'h0;
    end

    // entering program mode wipes the array
    if (n.st == hce_pkg::ST_PLOAD && r.st != hce_pkg::ST_PLOAD) begin
      n.mem = '0;
      n.widx = 4'h0;
      n.bitcnt = 4'h0;
      n.shreg = 16'h0;
      n.prog_done = 1'b0;
      n.vbit = 8'h0;
    end

    // led blink timer only runs while transmitting
    if (n.st == hce_pkg::ST_SEND || n.st == hce_pkg::ST_GUARD) begin
      if (r.led_cnt == LED_HALF_CYC - 25'h1) begin
        n.led_cnt = 25'h0;
        n.led_tog = ~r.led_tog;
      end else begin
        n.led_cnt = r.led_cnt + 25'h1;
      end
    end else begin
      n.led_cnt = 25'h0;
      n.led_tog = 1'b0;
    end

    // pin level: pwm thirds while sending, stored bit while verifying
    unique case (n.st)
      hce_pkg::ST_SEND:
        n.pin_out = !n.blank && (n.phase == 2'h0 ||
                    (n.phase == 2'h1 && !n.word[n.bit_idx]));
      hce_pkg::ST_PVERIFY: n.pin_out = n.mem[n.vbit[7:4]][n.vbit[3:0]];
      default: n.pin_out = 1'b0;
    endcase

    // ****************************************
    // apb register access
    // ****************************************
    if (acc && pwrite) begin
      unique case (paddr)
        `HCE_OFF_CTRL: n.auto_off = pwdata[0];
        `HCE_OFF_HOP: n.hop = pwdata;
        `HCE_OFF_ENVSN: n.env_sn = pwdata[27:0];
        default: n.auto_off = n.auto_off;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `HCE_OFF_CTRL: n.prdata = {31'h0, r.auto_off};
        `HCE_OFF_HOP: n.prdata = r.hop;
        `HCE_OFF_ENVSN: n.prdata = {4'h0, r.env_sn};
        `HCE_OFF_STATUS:
          n.prdata = {16'h0, r.widx, 3'h0, r.prog_done, r.blank,
                      r.word.repeat_flag, r.word.low_battery_flag, r.led_tog, 1'b0, r.st};
        `HCE_OFF_CONFIG: n.prdata = {16'h0, cfg};
        default: n.prdata = 32'h0;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= hce_pkg::ST_SLEEP;
      r.auto_off <= `HCE_RST_CTRL;
      r.hop <= `HCE_RST_HOP;
      r.env_sn <= `HCE_RST_ENVSN;
    end else begin
      r <= n;
    end
  end

  // outputs; zero-wait slave, error on unmapped addresses
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = r.prdata;
  assign sdata_out = r.pin_out;
  assign sdata_oe = (r.st == hce_pkg::ST_SEND) ||
                    (r.st == hce_pkg::ST_PVERIFY);
  assign vtrip_high_sel = cfg[`HCE_CFG_VTRIP];
  assign led = (r.st == hce_pkg::ST_SEND || r.st == hce_pkg::ST_GUARD) ?
               (r.word.low_battery_flag & r.led_tog) : 1'b1;

endmodule // hce_encoder

// ==== verification/hce_monitor.sv ====
// port checker for the encoder control block
`timescale 1ns/1ps
module hce_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // buttons and data pin
  input wire logic button_input_0,
  input wire logic button_input_1,
  input wire logic button_input_2,
  input wire logic button_input_3_prog_clock,
  input wire logic sdata_out,
  input wire logic sdata_oe
);
  logic mapped;
  logic btn;
  // five word registers, every other address is refused
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  assign btn = button_input_0 | button_input_1 | button_input_2 |
    button_input_3_prog_clock;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_PREADY: assert property (psel && penable |-> pready)
    else $error("access phase without pready");
  AST_ERR: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  AST_NOERR: assert property (!(psel && penable) || mapped |-> !pslverr)
    else $error("error flag on a good access");
  AST_RDZ: assert property (psel && !penable && !pwrite && !mapped |=>
    prdata == 32'h0) else $error("unmapped read not zero");
  // read data must not drift between reads
  AST_HOLD: assert property (!(psel && !penable && !pwrite) |=>
    $stable(prdata)) else $error("read data moved outside a read");
  AST_WAKE: assert property (
    $rose(sdata_oe) |-> $past(btn) || $past(btn, 2))
    else $error("pin driven without a button");
  AST_IDLE: assert property (
    !sdata_oe && !btn && !$past(btn) && !$past(btn, 2) |=> !sdata_oe)
    else $error("word started with no button");
  // button 3 low keeps verify clocking out of this one
  AST_ELEM: assert property (
    $rose(sdata_out) && sdata_oe && !button_input_3_prog_clock |->
    sdata_out [*4]) else $error("high element shorter than four cycles");
endmodule // hce_monitor

bind hce_encoder hce_monitor hce_monitor_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .button_input_0,
  .button_input_1, .button_input_2, .button_input_3_prog_clock, .sdata_out,
  .sdata_oe);

// ==== verification/hce_rx_model.sv ====
// receiver and data pin model facing the encoder
`timescale 1ns/1ps
module hce_rx (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin drivers and settings
  input wire logic sdata_out,
  input wire logic sdata_oe,
  input wire logic host_oe,
  input wire logic host_val,
  input wire logic listen,
  input wire logic [7:0] te,
  // resolved pin and decoded word
  output logic pin,
  output logic [65:0] word,
  output logic got
);
  logic [65:0] sr;
  logic prev;
  int nbit;
  int gap;
  // host forcing wins, a released line sits on the pulldown
  assign pin = host_oe ? host_val : (sdata_oe ? sdata_out : 1'b0);
  // middle element carries the inverted bit; odd rise spacing means abort
  always @(posedge pclk) begin
    prev <= sdata_out;
    got <= 1'b0;
    gap <= gap + 1;
    if (!presetn || !listen) begin
      nbit <= 0;
    end else if (sdata_oe && sdata_out && !prev) begin
      gap <= 1;
      if (gap != 3 * te) nbit <= 0;
    end else if (sdata_oe && gap == te + te / 2) begin
      sr <= {~sdata_out, sr[65:1]};
      nbit <= nbit + 1;
      if (nbit == 65) begin
        word <= {~sdata_out, sr[65:1]};
        got <= 1'b1;
        nbit <= 0;
      end
    end
  end
endmodule // hce_rx

// ==== verification/testbench.sv ====
// self-checking bench for the encoder control block
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] b = 4'h0;
  logic supply_low = 1'b0;
  logic host_oe = 1'b0;
  logic host_val = 1'b0;
  logic listen = 1'b0;
  logic [7:0] te = 8'h10;
  logic led_q = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, sdata_out, sdata_oe, vtrip_high_sel, led, pin, got;
  logic [65:0] word;
  logic [31:0] hop;
  logic [27:0] env;
  logic [15:0] mem [12];
  logic [31:0] exp_rd [$];
  hce_pkg::hce_word_t exp_w [$];
  int n_errors = 0;
  int checks_done = 0;
  int n_led = 0;
  int n0;

  // short counts keep the run small
  hce_encoder #(.TE100_CYC(20'h4), .LED_HALF_CYC(25'h8),
    .SHUTOFF_CYC(35'hC8), .PSETUP_MIN_CYC(21'h14),
    .PSETUP_MAX_CYC(21'h28)) hce_encoder_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .button_input_0(b[0]), .button_input_1(b[1]), .button_input_2(b[2]),
    .button_input_3_prog_clock(b[3]), .sdata_in(pin), .sdata_out, .sdata_oe,
    .supply_low, .vtrip_high_sel, .led);
  hce_rx hce_rx_i (.pclk, .presetn, .sdata_out, .sdata_oe, .host_oe,
    .host_val, .listen, .te, .pin, .word, .got);

  initial begin
    forever #2 pclk = ~pclk;
  end

  // ****************
  // tasks
  // ****************
  task automatic check(input logic [65:0] seen, input logic [65:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // quiet means the pin released for longer than any guard
  task automatic idle();
    int k;
    k = 0;
    while (k < 300) begin
      @(posedge pclk);
      k = sdata_oe ? 0 : k + 1;
    end
  endtask

  task automatic prog_nv(input logic [15:0] cfg);
    int i;
    listen <= 1'b0;
    for (i = 0; i < 12; i++) mem[i] = 16'($urandom);
    mem[11] = cfg;
    b[3] <= 1'b1;
    repeat (30) @(posedge pclk);
    host_oe <= 1'b1;
    host_val <= 1'b1;
    repeat (2) @(posedge pclk);
    b[3] <= 1'b0;
    repeat (4) @(posedge pclk);
    for (i = 0; i < 192; i++) begin
      host_val <= mem[i / 16][i % 16];
      @(posedge pclk);
      b[3] <= 1'b1;
      repeat (3) @(posedge pclk);
      b[3] <= 1'b0;
      repeat (i % 16 == 15 ? 4 : 2) @(posedge pclk);
    end
    host_oe <= 1'b0;
    repeat (2) @(posedge pclk);
    for (i = 0; i < 192; i++) begin
      check(66'(pin), 66'(mem[i / 16][i % 16]));
      b[3] <= 1'b1;
      repeat (3) @(posedge pclk);
      b[3] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    // a second read-back pass is refused: the pin stays released
    b[3] <= 1'b1;
    repeat (3) @(posedge pclk);
    check(66'(sdata_oe), 66'(0));
    b[3] <= 1'b0;
    idle();
  endtask

  // notes the expected words, then presses and waits for quiet
  task automatic press(input logic [3:0] pre, input logic [3:0] btn,
                       input int hold, input int n, input logic lo);
    hce_pkg::hce_word_t w;
    int i;
    w.low_battery_flag = lo;
    w.btn = btn;
    w.serial = mem[11][15] ? env : {mem[7][11:0], mem[6]};
    w.enc = &btn ? {mem[9], mem[8]} : hop;
    for (i = 0; i < n; i++) begin
      w.repeat_flag = (i > 0);
      exp_w.push_back(w);
    end
    supply_low <= lo;
    if (pre != 4'h0) begin
      b <= pre;
      // abort lands in a low element, so the new word opens with a rise
      repeat (280) @(posedge pclk);
    end
    b <= btn;
    repeat (hold) @(posedge pclk);
    b <= 4'h0;
    idle();
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // result watcher: oldest note against each result seen
  always @(posedge pclk) begin
    if (psel && penable && !pwrite) begin
      check(66'(prdata), 66'(exp_rd.pop_front()));
    end
    if (got === 1'b1) check(word, 66'(exp_w.pop_front()));
    if (led !== led_q) n_led++;
    led_q <= led;
  end

  initial begin
    repeat (80000) @(posedge pclk);
    n_errors++;
    conclude();
  end

  initial begin
    int j;
    void'($urandom(32'hE477));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (j = 0; j < 24; j += 4) rdc(8'(j), 32'h0);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    rdc(8'h0C, 32'h0);
    hop = $urandom;
    apb(1'b1, 8'h04, hop);
    rdc(8'h04, hop);
    prog_nv({4'h1, 12'($urandom)});
    rdc(8'h10, {16'h0, mem[11]});
    check(66'(vtrip_high_sel), 66'(1));
    listen <= 1'b1;
    n0 = n_led;
    press(4'h0, 4'h1, 5, 1, 1'b0);
    check(66'(n_led - n0), 66'(2));
    press(4'h0, 4'hF, 5, 1, 1'b0);
    n0 = n_led;
    press(4'h0, 4'h4, 3900, 2, 1'b1);
    check(66'(n_led - n0 > 6), 66'(1));
    press(4'h1, 4'h3, 300, 1, 1'b0);
    apb(1'b1, 8'h00, 32'h1);
    b <= 4'h2;
    repeat (400) @(posedge pclk);
    check(66'(sdata_oe), 66'(0));
    b <= 4'h0;
    idle();
    apb(1'b1, 8'h00, 32'h0);
    prog_nv({4'hE, 12'($urandom)});
    check(66'(vtrip_high_sel), 66'(0));
    env = 28'($urandom);
    apb(1'b1, 8'h08, 32'(env));
    rdc(8'h08, 32'(env));
    te <= 8'h4;
    listen <= 1'b1;
    // one in four: the second slot is silent, so only one word arrives
    press(4'h0, 4'h1, 1000, 1, 1'b0);
    press(4'h0, 4'h1, 3608, 2, 1'b0);
    conclude();
  end
endmodule // testbench
